// >>> design/scau_defines.vh
// register map, field positions and masks of the scan counter unit
`ifndef SCAU_DEFINES_VH
`define SCAU_DEFINES_VH
`define SCAU_A_CNT 6'h00
`define SCAU_A_CST 6'h04
`define SCAU_A_PCNT 6'h08
`define SCAU_A_PCST 6'h0c
`define SCAU_A_PRE 6'h10
`define SCAU_A_PPRE 6'h14
`define SCAU_A_OPND 6'h18
`define SCAU_A_MST 6'h1c
`define SCAU_A_ACC 6'h20
`define SCAU_A_SCAN 6'h24
`define SCAU_A_IST 6'h28
`define SCAU_A_IEN 6'h2c
`define SCAU_A_ICLR 6'h30
`define SCAU_B_ZERO 0
`define SCAU_B_LT 1
`define SCAU_B_EQ 2
`define SCAU_B_GT 3
`define SCAU_B_INC 4
`define SCAU_B_DEC 5
`define SCAU_B_LD 6
`define SCAU_B_HINC 7
`define SCAU_B_HDEC 8
`define SCAU_B_HLD 9
`define SCAU_B_FLAG 0
`define SCAU_B_HACC 3
`define SCAU_B_ACC1 16
`define SCAU_B_MOP 17
`define SCAU_B_GO 0
`define SCAU_CTL_MASK 16'h0070
`define SCAU_ST_MASK 16'h03ff
`define SCAU_W0 16'h0000
`define SCAU_ONE 16'h0001
`define SCAU_IRQ_W 4
`define SCAU_EV_FLAG 0
`define SCAU_EV_WRAP 1
`define SCAU_EV_PWRAP 2
`define SCAU_EV_SCAN 3
`endif

// >>> design/scau_top.v
// scan counter and add/sub unit with ahb-lite register slave
// What this block does
// RULE_01: increment rising edge adds one, wraps
// RULE_02: decrement rising edge subtracts one, wraps
// RULE_03: load rising edge copies preset into count
// RULE_04: zero flag follows count equal zero
// RULE_05: below flag when count under preset
// RULE_06: equal flag when count matches preset
// RULE_07: above flag when count over preset
// RULE_08: keep last-scan control levels as history
// RULE_09: persistent counter behaves same, survives power
// RULE_10: accumulator bit rising adds operand, writes back
// RULE_11: carry out sets overflow, keep low bits
// RULE_12: accumulator bit rising subtracts, writes back
// RULE_13: borrow sets underflow, keep wrapped value
// RULE_14: keep last-scan accumulator bit as history
// RULE_15: edge is level one with history zero
`timescale 1ns/1ns
`include "scau_defines.vh"
module scau_top (
   input wire clk,
   input wire arst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg irq,
   output reg scan_done
);
   reg [15:0] cnt_reg;
   reg [15:0] cst_reg;
   reg [15:0] pcnt_reg;
   reg [15:0] pcst_reg;
   reg [15:0] pre_reg;
   reg [15:0] ppre_reg;
   reg [15:0] opnd_reg;
   reg [15:0] mst_reg;
   reg [15:0] acc_reg;
   reg acc1_reg;
   reg mop_reg;
   reg [`SCAU_IRQ_W-1:0] ist_reg;
   reg [`SCAU_IRQ_W-1:0] ien_reg;
   reg wr_pend_reg;
   reg [5:0] wa_reg;
   reg scan_go;
   reg [15:0] cnt_next;
   reg [15:0] cst_next;
   reg [15:0] pcnt_next;
   reg [15:0] pcst_next;
   reg [15:0] opnd_next;
   reg [15:0] mst_next;
   reg [`SCAU_IRQ_W-1:0] ev;
   reg [16:0] sum;
   reg [16:0] diff;
   reg [31:0] rd;
   wire take;
   wire wr_hit;
   wire [15:0] wd;
   assign take = hsel & hready & htrans[1];
   assign wr_hit = wr_pend_reg;
   assign wd = hwdata[15:0];

   // one counter evaluation per scan; both variants share this function
   function [31:0] cnt_eval;
      input [15:0] c;
      input [15:0] s;
      input [15:0] k;
      reg [15:0] n;
      reg [15:0] t;
      begin
         n = c;
         // RULE_15 edge against history
         // RULE_03 preset load
         if (s[`SCAU_B_LD] && !s[`SCAU_B_HLD])
            n = k;
         // RULE_01 count up wraps
         if (s[`SCAU_B_INC] && !s[`SCAU_B_HINC])
            n = n + `SCAU_ONE;
         // RULE_02 count down wraps
         if (s[`SCAU_B_DEC] && !s[`SCAU_B_HDEC])
            n = n - `SCAU_ONE;
         // unused upper bits forced low so unreset words settle after a scan
         t = s & `SCAU_ST_MASK;
         // RULE_04 zero flag
         t[`SCAU_B_ZERO] = (n == `SCAU_W0);
         // RULE_05 below preset
         t[`SCAU_B_LT] = (n < k);
         // RULE_06 equal preset
         t[`SCAU_B_EQ] = (n == k);
         // RULE_07 above preset
         t[`SCAU_B_GT] = (n > k);
         // RULE_08 history after evaluation
         t[`SCAU_B_HINC] = s[`SCAU_B_INC];
         t[`SCAU_B_HDEC] = s[`SCAU_B_DEC];
         t[`SCAU_B_HLD] = s[`SCAU_B_LD];
         cnt_eval = {t, n};
      end
   endfunction

   always @* begin
      cnt_next = cnt_reg;
      cst_next = cst_reg;
      pcnt_next = pcnt_reg;
      pcst_next = pcst_reg;
      opnd_next = opnd_reg;
      mst_next = mst_reg;
      ev = {`SCAU_IRQ_W{1'b0}};
      sum = {1'b0, opnd_reg} + {1'b0, acc_reg};
      diff = {1'b0, opnd_reg} - {1'b0, acc_reg};
      if (scan_go) begin
         {cst_next, cnt_next} = cnt_eval(cnt_reg, cst_reg, pre_reg);
         // RULE_09 persistent variant same logic
         {pcst_next, pcnt_next} = cnt_eval(pcnt_reg, pcst_reg, ppre_reg);
         ev[`SCAU_EV_SCAN] = 1'b1;
         ev[`SCAU_EV_WRAP] = cst_next[`SCAU_B_ZERO] &
            ~cst_reg[`SCAU_B_ZERO];
         ev[`SCAU_EV_PWRAP] = pcst_next[`SCAU_B_ZERO] &
            ~pcst_reg[`SCAU_B_ZERO];
         // RULE_15 accumulator edge
         if (acc1_reg && !mst_reg[`SCAU_B_HACC]) begin
            if (!mop_reg) begin
               // RULE_10 add and write back
               opnd_next = sum[15:0];
               // RULE_11 overflow flag
               mst_next[`SCAU_B_FLAG] = sum[16];
            end else begin
               // RULE_12 subtract and write back
               opnd_next = diff[15:0];
               // RULE_13 underflow flag
               mst_next[`SCAU_B_FLAG] = diff[16];
            end
            ev[`SCAU_EV_FLAG] = mst_next[`SCAU_B_FLAG];
         end
         // RULE_14 accumulator history
         mst_next[`SCAU_B_HACC] = acc1_reg;
      end
   end

   always @* begin
      case (haddr[5:0])
         `SCAU_A_CNT: rd = {16'h0000, cnt_reg};
         `SCAU_A_CST: rd = {16'h0000, cst_reg};
         `SCAU_A_PCNT: rd = {16'h0000, pcnt_reg};
         `SCAU_A_PCST: rd = {16'h0000, pcst_reg};
         `SCAU_A_PRE: rd = {16'h0000, pre_reg};
         `SCAU_A_PPRE: rd = {16'h0000, ppre_reg};
         `SCAU_A_OPND: rd = {16'h0000, opnd_reg};
         `SCAU_A_MST: rd = {14'h0000, mop_reg, acc1_reg, mst_reg};
         `SCAU_A_ACC: rd = {16'h0000, acc_reg};
         `SCAU_A_IST: rd = {28'h0000000, ist_reg};
         `SCAU_A_IEN: rd = {28'h0000000, ien_reg};
         default: rd = 32'h00000000;
      endcase
   end

   // the persistent words have no reset so their content survives power
   // loss in a retention implementation; they start unknown in simulation
   always @(posedge clk) begin
      pcnt_reg <= pcnt_next;
      pcst_reg <= pcst_next;
      if (wr_hit && wa_reg == `SCAU_A_PCNT)
         pcnt_reg <= wd;
      if (wr_hit && wa_reg == `SCAU_A_PCST)
         pcst_reg <= (pcst_next & ~`SCAU_CTL_MASK) | (wd & `SCAU_CTL_MASK);
      if (wr_hit && wa_reg == `SCAU_A_PPRE)
         ppre_reg <= wd;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 16'h0000;
         cst_reg <= 16'h0000;
         pre_reg <= 16'h0000;
         opnd_reg <= 16'h0000;
         mst_reg <= 16'h0000;
         acc_reg <= 16'h0000;
         acc1_reg <= 1'b0;
         mop_reg <= 1'b0;
         ist_reg <= 4'h0;
         ien_reg <= 4'h0;
         wr_pend_reg <= 1'b0;
         wa_reg <= 6'h00;
         scan_go <= 1'b0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= 1'b0;
         scan_done <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         cst_reg <= cst_next;
         opnd_reg <= opnd_next;
         mst_reg <= mst_next;
         scan_go <= 1'b0;
         scan_done <= scan_go;
         wr_pend_reg <= take & hwrite;
         if (take)
            wa_reg <= haddr[5:0];
         // read data launched at the address edge so it stands in the
         // data phase, zero wait state
         if (take && !hwrite)
            hrdata <= rd;
         if (wr_hit) begin
            case (wa_reg)
               `SCAU_A_CNT: cnt_reg <= wd;
               // software writes only the control bits, scan owns flags
               `SCAU_A_CST: cst_reg <= (cst_next & ~`SCAU_CTL_MASK) |
                  (wd & `SCAU_CTL_MASK);
               `SCAU_A_PRE: pre_reg <= wd;
               `SCAU_A_OPND: opnd_reg <= wd;
               `SCAU_A_MST: begin
                  acc1_reg <= hwdata[`SCAU_B_ACC1];
                  mop_reg <= hwdata[`SCAU_B_MOP];
               end
               `SCAU_A_ACC: acc_reg <= wd;
               `SCAU_A_SCAN: scan_go <= hwdata[`SCAU_B_GO];
               `SCAU_A_IEN: ien_reg <= hwdata[`SCAU_IRQ_W-1:0];
               default: ;
            endcase
         end
         // set wins over clear
         if (wr_hit && wa_reg == `SCAU_A_ICLR)
            ist_reg <= (ist_reg & ~hwdata[`SCAU_IRQ_W-1:0]) | ev;
         else
            ist_reg <= ist_reg | ev;
         irq <= |(ist_reg & ien_reg);
      end
   end
endmodule // scau_top

// >>> sim/scau_top_sva.sv
// port-level checker for the scan counter unit
`timescale 1ns/1ns
module scau_top_sva (
   input wire clk,
   input wire arst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire irq,
   input wire scan_done
);
   wire rd = hsel && htrans[1] && !hwrite;
   wire wr = hsel && htrans[1] && hwrite;
   reg ran_reg;
   // flags are only defined once a scan has run
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         ran_reg <= 1'b0;
      else if (scan_done)
         ran_reg <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ready_high_a: assert property (hreadyout) else $error("wait state");
   resp_okay_a: assert property (!hresp) else $error("error response");
   done_pulse_a: assert property (scan_done |=> !scan_done)
      else $error("scan done too long");
   done_cause_a: assert property (wr && haddr[5:0] == 6'h24 ##1 hwdata[0]
      |-> ##[1:4] scan_done) else $error("scan not run");
   rd_unmapped_a: assert property (rd && haddr[5:0] > 6'h30
      |=> hrdata == 32'h0) else $error("unmapped read");
   ist_width_a: assert property (rd && haddr[5:0] == 6'h28
      |=> hrdata[31:4] == 28'h0) else $error("irq status width");
   cnt_width_a: assert property (rd && haddr[5:4] == 2'h0
      |=> hrdata[31:16] == 16'h0) else $error("counter word width");
   flag_onehot_a: assert property (ran_reg && rd
      && haddr[5:0] == 6'h04 |=> $onehot(hrdata[3:1]))
      else $error("compare flags");
   rst_quiet_a: assert property ($rose(arst_n)
      |-> !irq && !scan_done && hrdata == 32'h0) else $error("reset");
   cover property (scan_done);
   cover property ($rose(irq));
   cover property ($fell(irq));
endmodule // scau_top_sva
bind scau_top scau_top_sva chk_u (.clk(clk), .arst_n(arst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
   .scan_done(scan_done));

// >>> sim/scau_master.sv
// ahb-lite master standing in for the logic program
`timescale 1ns/1ns
module scau_master (
   input wire clk,
   input wire hready,
   input wire [31:0] hrdata,
   output reg hsel = 1'b0,
   output reg [31:0] haddr = 32'h0,
   output reg [1:0] htrans = 2'h0,
   output reg hwrite = 1'b0,
   output reg [2:0] hsize = 3'h2,
   output reg [31:0] hwdata = 32'h0,
   output reg tmo = 1'b0
);
   // bounded wait for ready; a stuck slave raises tmo
   task wt;
      integer n;
      begin
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (!hready && n < 16);
         if (!hready)
            tmo = 1'b1;
      end
   endtask
   task xfer(input w, input [5:0] a, input [31:0] d, output [31:0] r);
      begin
         @(posedge clk);
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {26'h0, a};
         wt;
         htrans <= 2'h0;
         hwdata <= d;
         wt;
         r = hrdata;
      end
   endtask
endmodule // scau_master

// >>> sim/test_scan_counter_add_sub_unit.sv
// self-checking bench for the scan counter unit
`timescale 1ns/1ns
module test_scan_counter_add_sub_unit;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   wire hsel, hwrite, hreadyout, hresp, irq, scan_done, tmo;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   integer error_cnt = 0;
   integer comparisons = 0;
   reg [31:0] r;
   always #20 clk = ~clk;
   scau_top dut_u (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .scan_done(scan_done));
   scau_master bus_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .tmo(tmo));
   task summarize;
      begin
         if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task rd(input [5:0] a, input [31:0] e);
      begin
         bus_u.xfer(1'b0, a, 32'h0, r);
         chk(r, e);
      end
   endtask
   task wr(input [5:0] a, input [31:0] d);
      bus_u.xfer(1'b1, a, d, r);
   endtask
   task scan;
      integer n;
      begin
         wr(6'h24, 32'h1);
         n = 0;
         // look just after the edge so the registered pulse has settled
         while (scan_done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         chk({31'h0, scan_done}, 32'h1);
         if (scan_done !== 1'b1)
            summarize;
         repeat (2) @(posedge clk);
      end
   endtask
   task cstep(input [5:0] b, input [15:0] c, input [15:0] e, input [15:0] s);
      begin
         wr(b + 6'h4, {16'h0, c});
         scan;
         rd(b, {16'h0, e});
         rd(b + 6'h4, {16'h0, s});
      end
   endtask
   task mstep(input [31:0] m, input [15:0] o, input [31:0] s);
      begin
         wr(6'h1c, 32'h0);
         scan;
         wr(6'h1c, m);
         scan;
         rd(6'h18, {16'h0, o});
         rd(6'h1c, s);
      end
   endtask
   task t_reset;
      begin
         rd(6'h28, 32'h0);
         rd(6'h34, 32'h0);
         chk({31'h0, irq}, 32'h0);
         wr(6'h08, 32'h1);
         wr(6'h0c, 32'h0);
         wr(6'h14, 32'h10);
      end
   endtask
   task t_count;
      begin
         wr(6'h10, 32'h5);
         cstep(6'h0, 16'h40, 16'h5, 16'h244);
         cstep(6'h0, 16'h20, 16'h4, 16'h122);
         cstep(6'h0, 16'h20, 16'h4, 16'h122);
         cstep(6'h0, 16'h10, 16'h5, 16'h94);
         wr(6'h10, 32'h0);
         cstep(6'h0, 16'h40, 16'h0, 16'h245);
         cstep(6'h0, 16'h20, 16'hffff, 16'h128);
         cstep(6'h0, 16'h10, 16'h0, 16'h95);
      end
   endtask
   task t_keep;
      cstep(6'h08, 16'h10, 16'h2, 16'h92);
   endtask
   task t_irq;
      begin
         chk({31'h0, irq}, 32'h0);
         wr(6'h2c, 32'h2);
         repeat (2) @(posedge clk);
         chk({31'h0, irq}, 32'h1);
         wr(6'h30, 32'h2);
         repeat (2) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
         rd(6'h28, 32'h8);
      end
   endtask
   task t_math;
      begin
         wr(6'h18, 32'hfff0);
         wr(6'h20, 32'h20);
         mstep(32'h10000, 16'h10, 32'h10009);
         mstep(32'h30000, 16'hfff0, 32'h30009);
         wr(6'h18, 32'h1);
         mstep(32'h10000, 16'h21, 32'h10008);
         mstep(32'h30000, 16'h1, 32'h30008);
      end
   endtask
   always @(posedge tmo) begin
      error_cnt = error_cnt + 1;
      summarize;
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_count;
      t_keep;
      t_irq;
      t_math;
      summarize;
   end
endmodule // test_scan_counter_add_sub_unit
